// >>> rtl/aso_defs.vh
// Shared constants for the sample output interface
`ifndef ASO_DEFS_VH
`define ASO_DEFS_VH
`define ASO_SAMPLE_WIDTH 12
`define ASO_PIPE_LATENCY 7
`define ASO_MODE_WIDTH 2
`define ASO_MODE_GND 2'h0
`define ASO_MODE_THIRD 2'h1
`define ASO_MODE_TWO_THIRDS 2'h2
`define ASO_MODE_FULL 2'h3
`define ASO_MODE_RESET 2'h0
`define ASO_CLK_PERIOD_NS 10
`define ASO_DLL_RELOCK_CYCLES 7'h64
`define ASO_BUF_DEPTH 2
`endif

// >>> rtl/aso_sample_output.v
// Sample output path: pipeline, format select, standby and output drive
// What this block does
// RULE_01 - Each sample appears on outputs seven clocks after its sampling edge; a stall delays words in flight and drops samples while the buffer is full.
// RULE_02 - Output word updates once per clock, valid after each rising edge; a valid word is held while sampleReady is low.
// RULE_03 - Mode level selects format and stabilizer per four-level table.
// RULE_04 - Mode defaults to ground level: offset binary, stabilizer off.
// RULE_05 - Host should clock no slower than 1 MSPS.
// RULE_06 - Sample words are twelve bits, all bits updated together.
// RULE_07 - Power-down high: standby, data drivers released; low resumes.
// RULE_08 - Host allows about 100 clocks for stabilizer relock after rate change.
// RULE_09 - Twos complement equals offset binary with MSB inverted.
`timescale 1ns/10ps
`include "aso_defs.vh"
module aso_sample_output #(
	parameter WIDTH = `ASO_SAMPLE_WIDTH,
	parameter LATENCY = `ASO_PIPE_LATENCY
) (
	input wire mclk,
	input wire reset_n,
	input wire [WIDTH-1:0] convCode,
	input wire [`ASO_MODE_WIDTH-1:0] analogSupplyLevelMode,
	input wire modeConnected,
	input wire powerDownPin,
	input wire sampleReady,
	output reg [WIDTH-1:0] sampleOut,
	output reg sampleValid,
	output reg sampleOe,
	output reg twosComplement,
	output reg dutyCycleStabilizerOn,
	output reg relockBusy
);
	reg rstSync1_reg;
	reg rstSync2_reg;
	wire rstN;
	reg [`ASO_MODE_WIDTH-1:0] modeSync1_reg;
	reg [`ASO_MODE_WIDTH-1:0] modeSync2_reg;
	reg connSync1_reg;
	reg connSync2_reg;
	reg pdSync1_reg;
	reg pdSync2_reg;
	reg [WIDTH-1:0] pipe_reg [0:LATENCY-2];
	reg [LATENCY-2:0] pipeValid_reg;
	reg [WIDTH-1:0] formatted;
	reg [`ASO_MODE_WIDTH-1:0] effMode;
	reg [6:0] relock_reg;
	reg dcsPrev_reg;
	wire bufInReady;
	wire bufOutValid;
	wire [WIDTH-1:0] bufOutData;
	wire bufOutReady;
	integer i;

	function [WIDTH-1:0] toTwos;
		input [WIDTH-1:0] code;
		begin
			toTwos = {~code[WIDTH-1], code[WIDTH-2:0]}; // see RULE_09
		end
	endfunction

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync1_reg <= 1'b0;
			rstSync2_reg <= 1'b0;
		end else begin
			rstSync1_reg <= 1'b1;
			rstSync2_reg <= rstSync1_reg;
		end
	end
	assign rstN = rstSync2_reg;

	// Mode and power-down pins are asynchronous straps
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			modeSync1_reg <= `ASO_MODE_RESET;
			modeSync2_reg <= `ASO_MODE_RESET;
			connSync1_reg <= 1'b0;
			connSync2_reg <= 1'b0;
			pdSync1_reg <= 1'b0;
			pdSync2_reg <= 1'b0;
		end else begin
			modeSync1_reg <= analogSupplyLevelMode;
			modeSync2_reg <= modeSync1_reg;
			connSync1_reg <= modeConnected;
			connSync2_reg <= connSync1_reg;
			pdSync1_reg <= powerDownPin;
			pdSync2_reg <= pdSync1_reg;
		end
	end

	always @* begin
		// Floating pin reads as pulled to ground
		effMode = connSync2_reg ? modeSync2_reg : `ASO_MODE_GND; // see RULE_04
		formatted = pipe_reg[LATENCY-2];
		if (effMode == `ASO_MODE_FULL || effMode == `ASO_MODE_TWO_THIRDS) begin
			formatted = toTwos(pipe_reg[LATENCY-2]); // see RULE_03
		end
	end

	// Stages 1..LATENCY-1 here; the buffer entry and then the sampleOut register give the last two stages
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pipeValid_reg <= {(LATENCY-1){1'b0}};
			for (i = 0; i < LATENCY-1; i = i + 1) begin
				pipe_reg[i] <= {WIDTH{1'b0}};
			end
		end else if (bufInReady) begin
			pipe_reg[0] <= convCode; // see RULE_01
			pipeValid_reg <= {pipeValid_reg[LATENCY-3:0], ~pdSync2_reg};
			for (i = 1; i < LATENCY-1; i = i + 1) begin
				pipe_reg[i] <= pipe_reg[i-1];
			end
		end
	end

	aso_skid_buffer #(
		.WIDTH(WIDTH)
	) uBuf (
		.clk(mclk),
		.rstN(rstN),
		.inValid(pipeValid_reg[LATENCY-2]),
		.inReady(bufInReady),
		.inData(formatted),
		.outValid(bufOutValid),
		.outReady(bufOutReady),
		.outData(bufOutData)
	);
	assign bufOutReady = !sampleValid || sampleReady;

	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			sampleOut <= {WIDTH{1'b0}};
			sampleValid <= 1'b0;
			sampleOe <= 1'b0;
			twosComplement <= 1'b0;
			dutyCycleStabilizerOn <= 1'b0;
			dcsPrev_reg <= 1'b0;
			relock_reg <= 7'h00;
			relockBusy <= 1'b0;
		end else begin
			sampleOe <= ~pdSync2_reg; // see RULE_07
			twosComplement <= effMode[1];
			dutyCycleStabilizerOn <= effMode[1] ^ effMode[0]; // see RULE_03
			dcsPrev_reg <= dutyCycleStabilizerOn;
			if (dutyCycleStabilizerOn && !dcsPrev_reg) begin
				relock_reg <= `ASO_DLL_RELOCK_CYCLES;
				relockBusy <= 1'b1;
			end else if (relock_reg != 7'h00) begin
				relock_reg <= relock_reg - 7'h01;
				relockBusy <= (relock_reg != 7'h01);
			end
			if (bufOutReady) begin
				sampleValid <= bufOutValid; // see RULE_02
				if (bufOutValid) begin
					sampleOut <= bufOutData; // see RULE_06
				end
			end
		end
	end
endmodule

// >>> rtl/aso_skid_buffer.v
// Two-entry valid/ready buffer for sample words
`timescale 1ns/10ps
module aso_skid_buffer #(
	parameter WIDTH = 12
) (
	input wire clk,
	input wire rstN,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:1];
	reg wrPtr_reg;
	reg rdPtr_reg;
	reg [1:0] count_reg;
	wire doWrite;
	wire doRead;
	assign inReady = (count_reg != 2'h2);
	assign outValid = (count_reg != 2'h0);
	assign outData = mem[rdPtr_reg];
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;
	always @(posedge clk) begin
		if (doWrite) begin
			mem[wrPtr_reg] <= inData;
		end
	end
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_reg <= 1'b0;
			rdPtr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (doWrite) begin
				wrPtr_reg <= ~wrPtr_reg;
			end
			if (doRead) begin
				rdPtr_reg <= ~rdPtr_reg;
			end
			if (doWrite && !doRead) begin
				count_reg <= count_reg + 2'h1;
			end else if (doRead && !doWrite) begin
				count_reg <= count_reg - 2'h1;
			end
		end
	end
endmodule

// >>> testbench/aso_host_model.sv
// Host capture side that can stall the sample stream
`timescale 1ns/10ps
module aso_host_model (
	input wire mclk,
	input wire hold,
	output logic sampleReady
);
	// Bench clock is 100 MHz, far above the floor rate
	// Follows hold directly, so a stall starts on the edge the bench chose
	assign sampleReady = !hold;
endmodule

// >>> testbench/aso_sample_output_props.sv
// Port assertions for the sample output block
`timescale 1ns/10ps
module aso_sample_output_props #(parameter WIDTH = 12, parameter LATENCY = 7) (
	input wire mclk,
	input wire reset_n,
	input wire [WIDTH-1:0] convCode,
	input wire [1:0] analogSupplyLevelMode,
	input wire modeConnected,
	input wire powerDownPin,
	input wire sampleReady,
	input wire [WIDTH-1:0] sampleOut,
	input wire sampleValid,
	input wire sampleOe,
	input wire twosComplement,
	input wire dutyCycleStabilizerOn
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// A stall queues a word and adds latency until the stream shows a gap
	reg lagFree_reg;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lagFree_reg <= 1'b1;
		end else if (sampleValid && !sampleReady) begin
			lagFree_reg <= 1'b0;
		end else if (!sampleValid) begin
			lagFree_reg <= 1'b1;
		end
	end
	sequence s_run; sampleReady[*8]; endsequence
	sequence s_mode; (modeConnected && $stable(analogSupplyLevelMode))[*8]; endsequence
	property p_lat;
		s_run ##0 (lagFree_reg && sampleValid &&
			$past(twosComplement, LATENCY + 1) == twosComplement) |->
			sampleOut == ($past(convCode, LATENCY + 1) ^ {twosComplement, {WIDTH-1{1'b0}}});
	endproperty
	a_lat: assert property (p_lat) else $error("wrong word or latency");
	property p_mode;
		s_mode |-> twosComplement == analogSupplyLevelMode[1] &&
			dutyCycleStabilizerOn == ^analogSupplyLevelMode;
	endproperty
	a_mode: assert property (p_mode) else $error("mode decode wrong");
	property p_dflt; !modeConnected[*8] |-> !twosComplement && !dutyCycleStabilizerOn; endproperty
	a_dflt: assert property (p_dflt) else $error("floating mode wrong");
	property p_pd; powerDownPin[*5] |-> !sampleOe; endproperty
	a_pd: assert property (p_pd) else $error("driving in standby");
	property p_on; !powerDownPin[*8] |-> sampleOe; endproperty
	a_on: assert property (p_on) else $error("not driving");
	property p_stand; sampleValid && !sampleReady |=> sampleValid && $stable(sampleOut); endproperty
	a_stand: assert property (p_stand) else $error("word lost in stall");
endmodule
bind aso_sample_output aso_sample_output_props #(.WIDTH(WIDTH), .LATENCY(LATENCY)) i_props(.*);

// >>> testbench/test_adc_sample_output_interface.sv
// Testbench for the sample output block
`timescale 1ns/10ps
`include "aso_defs.vh"
module test_adc_sample_output_interface;
	logic mclk = 0, reset_n = 0, modeConnected = 0, powerDownPin = 0, hold = 0;
	logic [11:0] convCode = 0, sampleOut;
	logic [1:0] analogSupplyLevelMode = 0;
	logic sampleReady, sampleValid, sampleOe, twosComplement, dutyCycleStabilizerOn, relockBusy;
	int bad_count = 0, comparisons = 0;
	aso_sample_output i_aso_sample_output(.*);
	aso_host_model i_aso_host_model(.mclk(mclk), .hold(hold), .sampleReady(sampleReady));
	initial forever #5 mclk = ~mclk;
	task chk(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("bad %0d of %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task t_mode(input logic [1:0] m);
		analogSupplyLevelMode = m;
		modeConnected = 1;
		convCode = 12'hA5C;
		cyc(10);
		chk(relockBusy, m == 2'h1);
		cyc(`ASO_DLL_RELOCK_CYCLES);
		chk(relockBusy, 0);
		chk({twosComplement, dutyCycleStabilizerOn}, {m[1], m[1] ^ m[0]});
		convCode = 12'h3C1;
		cyc(7);
		chk(sampleOut, 12'hA5C ^ {m[1], 11'h0});
		cyc(1);
		chk(sampleOut, 12'h3C1 ^ {m[1], 11'h0});
	endtask
	task t_stall;
		hold = 1;
		cyc(2);
		convCode = 12'h7E2;
		cyc(5);
		chk({sampleValid, sampleOut}, {1'b1, 12'hBC1});
		hold = 0;
		cyc(14);
		chk(sampleOut, 12'hFE2);
	endtask
	task t_pd;
		powerDownPin = 1;
		cyc(5);
		chk(sampleOe, 0);
		powerDownPin = 0;
		cyc(14);
		chk({sampleOe, sampleValid}, 2'h3);
	endtask
	initial begin
		cyc(3);
		reset_n = 1;
		analogSupplyLevelMode = 3;
		cyc(12);
		chk({twosComplement, dutyCycleStabilizerOn}, 0);
		for (int m = 0; m < 4; m++) t_mode(m[1:0]);
		t_stall;
		t_pd;
		stop_test;
	end
	initial begin
		#50000;
		bad_count++;
		stop_test;
	end
endmodule
